// [logic/spc_consts.vh]
// register offsets, field positions, mode codes and bus constants for the serial port
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH
`define SPC_OFS_CONTROL     8'h98
`define SPC_OFS_BUFFER      8'h99
`define SPC_OFS_BAUD        8'h9C
`define SPC_BIT_MODE_HIGH   7
`define SPC_BIT_MODE_LOW    6
`define SPC_BIT_MP_EN       5
`define SPC_BIT_RX_EN       4
`define SPC_BIT_TX_NINTH    3
`define SPC_BIT_RX_NINTH    2
`define SPC_BIT_TX_DONE     1
`define SPC_BIT_RX_DONE     0
`define SPC_CONTROL_RESET   8'h00
`define SPC_BAUD_RESET      16'h000F
`define SPC_MODE_SHIFT      2'b00
`define SPC_MODE_VAR8       2'b01
`define SPC_MODE_FIX9       2'b10
`define SPC_MODE_VAR9       2'b11
`define SPC_HTRANS_NONSEQ   2'b10
`define SPC_SHIFT_DIV       16'h0003
`define SPC_FIX9_DIV        16'h001F
`endif

// [logic/spc_tx.v]
// serial transmit shifter: shift-mode clocked frames and asynchronous 8/9 bit frames
`timescale 1ns/100ps
`default_nettype none
`include "spc_consts.vh"
module spc_tx (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        bit_tick,
    input  wire [1:0]  mode,
    input  wire        start,
    input  wire [7:0]  data,
    input  wire        ninth,
    output reg         line_out,
    output reg         shift_clk_out,
    output reg         busy,
    output reg         done
);
    reg [10:0] shreg_reg;
    reg [3:0]  count_reg;
    wire       nine = mode[1];
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shreg_reg     <= 11'h7FF;
            count_reg     <= 4'h0;
            busy          <= 1'b0;
            done          <= 1'b0;
            line_out      <= 1'b1;
            shift_clk_out <= 1'b1;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                if (mode == `SPC_MODE_SHIFT) begin
                    shreg_reg <= {3'b111, data};
                    count_reg <= 4'd9;
                end else begin
                    // start bit, data lsb first, optional ninth bit, stop bit
                    shreg_reg <= nine ? {1'b1, ninth, data, 1'b0} : {2'b11, data, 1'b0};
                    count_reg <= nine ? 4'd12 : 4'd11;
                end
            end else if (busy && bit_tick) begin
                count_reg <= count_reg - 4'd1;
                if (count_reg == 4'd1) begin
                    // one extra tick so the last bit stands a full bit time before a new start
                    line_out <= 1'b1;
                    busy     <= 1'b0;
                    done     <= 1'b1;
                end else begin
                    line_out  <= shreg_reg[0];
                    shreg_reg <= {1'b1, shreg_reg[10:1]};
                    if (mode == `SPC_MODE_SHIFT)
                        shift_clk_out <= 1'b0;
                end
            end else if (bit_tick) begin
                shift_clk_out <= 1'b1;
                if (!busy)
                    line_out <= 1'b1;
            end else begin
                shift_clk_out <= 1'b1;
            end
        end
    end
endmodule // spc_tx
`default_nettype wire

// [logic/spc_rx.v]
// serial receive shifter: samples the synchronised line once per bit tick
`timescale 1ns/100ps
`default_nettype none
`include "spc_consts.vh"
module spc_rx (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        bit_tick,
    input  wire [1:0]  mode,
    input  wire        enable,
    input  wire        line_in,
    output reg  [7:0]  data,
    output reg         ninth,
    output reg         stop_ok,
    output reg         frame_done
);
    reg [9:0] shreg_reg;
    reg [3:0] count_reg;
    reg       active_reg;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shreg_reg  <= 10'h000;
            count_reg  <= 4'h0;
            active_reg <= 1'b0;
            data       <= 8'h00;
            ninth      <= 1'b0;
            stop_ok    <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            if (!enable) begin
                active_reg <= 1'b0;
            end else if (bit_tick) begin
                if (!active_reg) begin
                    // async frames start on a low line, shift mode starts at once
                    if (mode == `SPC_MODE_SHIFT || !line_in) begin
                        active_reg <= 1'b1;
                        count_reg  <= (mode == `SPC_MODE_SHIFT) ? 4'd8 :
                                      (mode[1] ? 4'd10 : 4'd9);
                        if (mode == `SPC_MODE_SHIFT) begin
                            shreg_reg <= {line_in, shreg_reg[9:1]};
                            count_reg <= 4'd7;
                        end
                    end
                end else begin
                    shreg_reg <= {line_in, shreg_reg[9:1]};
                    count_reg <= count_reg - 4'd1;
                    if (count_reg == 4'd1) begin
                        active_reg <= 1'b0;
                        frame_done <= 1'b1;
                        stop_ok    <= line_in;
                        if (mode == `SPC_MODE_SHIFT) begin
                            data  <= {line_in, shreg_reg[9:3]};
                            ninth <= 1'b0;
                        end else if (mode[1]) begin
                            data  <= shreg_reg[8:1];
                            ninth <= shreg_reg[9];
                        end else begin
                            data  <= shreg_reg[9:2];
                            ninth <= line_in;
                        end
                    end
                end
            end
        end
    end
endmodule // spc_rx
`default_nettype wire

// [logic/spc_top.v]
// serial port with control/status register, buffer register and ahb-lite slave
// How it works
// - mode comes from the two top bits of the control register.
// - nine-bit modes with multiprocessor enable: ninth bit zero sets no receive flag.
// - variable eight-bit mode with multiprocessor enable: bad stop bit sets no flag.
// - reception runs only while receive enable is one; only software changes it.
// - nine-bit modes send the software transmit ninth bit as bit nine.
// - nine-bit modes store the received ninth bit in the control register.
// - variable eight-bit mode without multiprocessor enable stores the stop bit there.
// - shift mode never loads the receive ninth bit.
// - shift mode sets transmit done after the eighth bit is out.
// - buffer reads return receive data; buffer writes load transmit data.
// - receiver is double buffered; an unread byte is overwritten by the next.
`timescale 1ns/100ps
`default_nettype none
`include "spc_consts.vh"
module spc_top #(
    parameter SHIFT_DIV = `SPC_SHIFT_DIV,
    parameter FIX9_DIV  = `SPC_FIX9_DIV
) (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        rxd_in,
    output reg         txd_out,
    output reg         txd_oe,
    output reg         shift_clk_out,
    output reg         rx_overrun
);
    reg  [7:0]  control_reg;
    reg  [7:0]  rx_buf_reg;
    reg  [15:0] baud_reg;
    reg  [15:0] div_cnt_reg;
    reg         bit_tick_reg;
    reg         rxd_meta_reg;
    reg         rxd_sync_reg;
    reg         ap_valid_reg;
    reg         ap_write_reg;
    reg  [7:0]  ap_addr_reg;
    reg         tx_start_reg;
    reg  [7:0]  tx_data_reg;
    reg         buf_unread_reg;
    reg  [15:0] div_limit;
    reg         rx_accept;
    reg  [31:0] read_data;
    wire [1:0]  mode = control_reg[`SPC_BIT_MODE_HIGH:`SPC_BIT_MODE_LOW];
    wire        mp_en = control_reg[`SPC_BIT_MP_EN];
    wire        tx_line;
    wire        tx_sclk;
    wire        tx_busy;
    wire        tx_done;
    wire [7:0]  rx_data;
    wire        rx_ninth;
    wire        rx_stop_ok;
    wire        rx_frame_done;
    wire        ap_take = hsel && hready && htrans == `SPC_HTRANS_NONSEQ;
    wire        wr_ctrl = ap_valid_reg && ap_write_reg && ap_addr_reg == `SPC_OFS_CONTROL;
    wire        wr_baud = ap_valid_reg && ap_write_reg && ap_addr_reg == `SPC_OFS_BAUD;
    wire        rd_buf  = ap_valid_reg && !ap_write_reg && ap_addr_reg == `SPC_OFS_BUFFER;

    // bit rate select: shift mode and fixed nine-bit mode use fixed dividers
    always @* begin
        if (mode == `SPC_MODE_SHIFT)
            div_limit = SHIFT_DIV[15:0];
        else if (mode == `SPC_MODE_FIX9)
            div_limit = FIX9_DIV[15:0];
        else
            div_limit = baud_reg;
    end

    // receive flag gating for multiprocessor addressing
    always @* begin
        rx_accept = 1'b1;
        if (mp_en && mode[1] && !rx_ninth)
            rx_accept = 1'b0;
        else if (mp_en && mode == `SPC_MODE_VAR8 && !rx_stop_ok)
            rx_accept = 1'b0;
    end

    // decoded at the address phase; a write still in its data phase is forwarded
    always @* begin
        read_data = 32'h0000_0000;
        if (haddr[7:0] == `SPC_OFS_CONTROL)
            read_data = {24'h00_0000, wr_ctrl ? hwdata[7:0] : control_reg};
        else if (haddr[7:0] == `SPC_OFS_BUFFER)
            read_data = {24'h00_0000, rx_buf_reg};
        else if (haddr[7:0] == `SPC_OFS_BAUD)
            read_data = {16'h0000, wr_baud ? hwdata[15:0] : baud_reg};
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxd_meta_reg <= 1'b1;
            rxd_sync_reg <= 1'b1;
            div_cnt_reg  <= 16'h0000;
            bit_tick_reg <= 1'b0;
        end else begin
            rxd_meta_reg <= rxd_in;
            rxd_sync_reg <= rxd_meta_reg;
            bit_tick_reg <= 1'b0;
            if (div_cnt_reg >= div_limit) begin
                div_cnt_reg  <= 16'h0000;
                bit_tick_reg <= 1'b1;
            end else begin
                div_cnt_reg <= div_cnt_reg + 16'h0001;
            end
        end
    end

    // ahb-lite slave: zero wait states, always okay, unmapped reads give zero
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg  <= 8'h00;
            hrdata       <= 32'h0000_0000;
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
        end else begin
            if (hready) begin
                ap_valid_reg <= ap_take;
                ap_write_reg <= hwrite;
                ap_addr_reg  <= haddr[7:0];
            end
            // loaded at the address edge so the word stands through the data phase
            if (ap_take && !hwrite)
                hrdata <= read_data;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            control_reg    <= `SPC_CONTROL_RESET;
            baud_reg       <= `SPC_BAUD_RESET;
            rx_buf_reg     <= 8'h00;
            tx_start_reg   <= 1'b0;
            tx_data_reg    <= 8'h00;
            buf_unread_reg <= 1'b0;
            rx_overrun     <= 1'b0;
        end else begin
            tx_start_reg <= 1'b0;
            if (wr_ctrl)
                control_reg <= hwdata[7:0];
            if (wr_baud)
                baud_reg <= hwdata[15:0];
            if (ap_valid_reg && ap_write_reg && ap_addr_reg == `SPC_OFS_BUFFER) begin
                tx_data_reg  <= hwdata[7:0];
                tx_start_reg <= 1'b1;
            end
            if (rd_buf)
                buf_unread_reg <= 1'b0;
            // hardware sets win over a software write in the same cycle
            if (tx_done)
                control_reg[`SPC_BIT_TX_DONE] <= 1'b1;
            if (rx_frame_done && rx_accept) begin
                rx_buf_reg     <= rx_data;
                buf_unread_reg <= 1'b1;
                rx_overrun     <= buf_unread_reg && !rd_buf;
                control_reg[`SPC_BIT_RX_DONE] <= 1'b1;
                if (mode != `SPC_MODE_SHIFT)
                    control_reg[`SPC_BIT_RX_NINTH] <= rx_ninth;
            end
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txd_out       <= 1'b1;
            txd_oe        <= 1'b0;
            shift_clk_out <= 1'b1;
        end else begin
            txd_out       <= tx_line;
            txd_oe        <= tx_busy;
            shift_clk_out <= tx_sclk;
        end
    end

    spc_tx u_tx (
        .clk           (clk),
        .reset_n       (reset_n),
        .bit_tick      (bit_tick_reg),
        .mode          (mode),
        .start         (tx_start_reg),
        .data          (tx_data_reg),
        .ninth         (control_reg[`SPC_BIT_TX_NINTH]),
        .line_out      (tx_line),
        .shift_clk_out (tx_sclk),
        .busy          (tx_busy),
        .done          (tx_done)
    );

    spc_rx u_rx (
        .clk        (clk),
        .reset_n    (reset_n),
        .bit_tick   (bit_tick_reg),
        .mode       (mode),
        .enable     (control_reg[`SPC_BIT_RX_EN]),
        .line_in    (rxd_sync_reg),
        .data       (rx_data),
        .ninth      (rx_ninth),
        .stop_ok    (rx_stop_ok),
        .frame_done (rx_frame_done)
    );
endmodule // spc_top
`default_nettype wire

// [testbench/spc_chk.sv]
// assertion checker on the serial port top-level ports
`timescale 1ns/100ps
`default_nettype none
module spc_chk (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        txd_out,
    input wire logic        txd_oe,
    input wire logic        shift_clk_out,
    input wire logic        rx_overrun
);
    logic       wr_ctl_reg;
    logic [4:0] ctl_shadow_reg;
    wire        req = hsel && hready && htrans == 2'b10;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // shadow of the software-owned control bits, hardware never alters them
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ctl_reg <= 1'b0;
            ctl_shadow_reg <= 5'h0;
        end else begin
            wr_ctl_reg <= req && hwrite && haddr[7:0] == 8'h98;
            if (wr_ctl_reg) ctl_shadow_reg <= hwdata[7:3];
        end
    end
    sequence s_rd(logic [7:0] a);
        req && !hwrite && haddr[7:0] == a;
    endsequence
    sequence s_unmapped;
        req && !hwrite && !(haddr[7:0] inside {8'h98, 8'h99, 8'h9C});
    endsequence
    AST_CTL_READBACK: assert property (s_rd(8'h98) |-> ##1 hrdata[31:3] == {24'h0, ctl_shadow_reg})
        else $error("control read lost a software bit");
    AST_UNMAPPED_ZERO: assert property (s_unmapped |-> ##1 hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_BAUD_UPPER: assert property (s_rd(8'h9C) |-> ##1 hrdata[31:16] == 16'h0)
        else $error("baud read upper half not zero");
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus stalled or error response");
    AST_TX_IDLE_HIGH: assert property (!txd_oe |-> txd_out)
        else $error("transmit line low while not sending");
    AST_SHIFT_PULSE: assert property ($fell(shift_clk_out) |=> shift_clk_out[*2])
        else $error("shift clock low phase too long");
    AST_OE_MIN_FRAME: assert property ($rose(txd_oe) |-> txd_oe[*8])
        else $error("transmit enable pulse too short");
    AST_OVERRUN_HOLD: assert property ($changed(rx_overrun) |=> $stable(rx_overrun)[*8])
        else $error("overrun flag toggled within a frame");
endmodule // spc_chk
bind spc_top spc_chk u_spc_chk (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .txd_out(txd_out), .txd_oe(txd_oe),
    .shift_clk_out(shift_clk_out), .rx_overrun(rx_overrun));
`default_nettype wire

// [testbench/spc_node.sv]
// remote serial node: sends and captures asynchronous frames
`timescale 1ns/100ps
`default_nettype none
module spc_node (
    input  wire logic clk,
    input  wire logic txd_out,
    output var  logic rxd_in
);
    initial rxd_in = 1'b1;
    // start bit, data lsb first, optional ninth bit, stop bit, then idle gap
    task automatic send(input logic [8:0] d, input logic use9, input logic stp, input int bc);
        logic [10:0] f;
        f = {stp, d[8], d[7:0], 1'b0};
        if (!use9) f[9] = stp;
        for (int i = 0; i < (use9 ? 11 : 10); i++) begin
            rxd_in <= f[i];
            repeat (bc) @(posedge clk);
        end
        rxd_in <= 1'b1;
        repeat (2 * bc) @(posedge clk);
    endtask
    // samples mid-bit, phase taken from the falling start edge
    task automatic grab(input logic use9, input int bc, output logic [8:0] d);
        d = 9'h0;
        @(negedge txd_out);
        repeat (bc / 2) @(posedge clk);
        for (int i = 0; i < (use9 ? 9 : 8); i++) begin
            repeat (bc) @(posedge clk);
            d[i] = txd_out;
        end
    endtask
endmodule // spc_node
`default_nettype wire

// [testbench/spc_top_tb.sv]
// self-checking bench for the serial port control and status block
`timescale 1ns/100ps
`default_nettype none
`include "spc_consts.vh"
module spc_top_tb;
    localparam int B = `SPC_BAUD_RESET + 1;
    localparam int F = `SPC_FIX9_DIV + 1;
    logic        clk, reset_n, hsel, hwrite;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [8:0]  got;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, rxd_in, txd_out, txd_oe, shift_clk_out, rx_overrun;
    int          n_mismatch, checks, cyc, n_sclk;
    spc_top u_spc_top (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd_in(rxd_in),
        .txd_out(txd_out), .txd_oe(txd_oe), .shift_clk_out(shift_clk_out),
        .rx_overrun(rx_overrun));
    spc_node u_spc_node (.clk(clk), .txd_out(txd_out), .rxd_in(rxd_in));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (!shift_clk_out) n_sclk++;
        if (cyc == 40000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // single word transfer; read data stands in the data phase and is taken at its closing edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= `SPC_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic poll(input int pos);
        repeat (40) begin
            bus(1'b0, `SPC_OFS_CONTROL, 32'h0);
            if (rd[pos] === 1'b1) break;
        end
    endtask
    task automatic t_regs();
        bus(1'b0, `SPC_OFS_CONTROL, 32'h0);
        chk(rd, {24'h0, `SPC_CONTROL_RESET});
        bus(1'b0, `SPC_OFS_BAUD, 32'h0);
        chk(rd, {16'h0, `SPC_BAUD_RESET});
        bus(1'b1, 8'h9F, 32'hFFFF_FFFF);
        bus(1'b0, 8'h9F, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, `SPC_OFS_CONTROL, 32'hF8);
        bus(1'b0, `SPC_OFS_CONTROL, 32'h0);
        chk(rd & 32'hF8, 32'hF8);
        $display("test regs done");
    endtask
    task automatic t_shift();
        bus(1'b1, `SPC_OFS_CONTROL, 32'h0);
        n_sclk = 0;
        bus(1'b1, `SPC_OFS_BUFFER, 32'hA5);
        poll(`SPC_BIT_TX_DONE);
        chk({31'h0, rd[`SPC_BIT_TX_DONE]}, 32'h1);
        chk(n_sclk, 32'h8);
        bus(1'b1, `SPC_OFS_CONTROL, 32'h14);
        poll(`SPC_BIT_RX_DONE);
        chk({31'h0, rd[`SPC_BIT_RX_NINTH]}, 32'h1);
        bus(1'b0, `SPC_OFS_BUFFER, 32'h0);
        chk(rd, 32'hFF);
        $display("test shift done");
    endtask
    task automatic t_tx9(input logic [7:0] ctl, input int bc);
        bus(1'b1, `SPC_OFS_CONTROL, {24'h0, ctl});
        fork
            u_spc_node.grab(1'b1, bc, got);
            bus(1'b1, `SPC_OFS_BUFFER, 32'h5A);
        join
        chk({23'h0, got}, {23'h0, ctl[`SPC_BIT_TX_NINTH], 8'h5A});
        poll(`SPC_BIT_TX_DONE);
        chk({31'h0, rd[`SPC_BIT_TX_DONE]}, 32'h1);
        $display("test tx9 done");
    endtask
    task automatic t_rx(input logic [7:0] ctl, input logic [8:0] d, input logic stp,
                        input int bc, input logic done, input logic rb8);
        bus(1'b1, `SPC_OFS_CONTROL, {24'h0, ctl});
        u_spc_node.send(d, ctl[7], stp, bc);
        poll(`SPC_BIT_RX_DONE);
        chk({31'h0, rd[`SPC_BIT_RX_DONE]}, {31'h0, done});
        if (done) begin
            chk({31'h0, rd[`SPC_BIT_RX_NINTH]}, {31'h0, rb8});
            bus(1'b0, `SPC_OFS_BUFFER, 32'h0);
            chk(rd, {24'h0, d[7:0]});
            bus(1'b0, `SPC_OFS_CONTROL, 32'h0);
            chk({31'h0, rd[`SPC_BIT_RX_DONE]}, 32'h1);
        end
        $display("test rx done");
    endtask
    // second byte lands while the first is still unread
    task automatic t_overrun();
        bus(1'b1, `SPC_OFS_CONTROL, 32'h50);
        bus(1'b0, `SPC_OFS_BUFFER, 32'h0);
        u_spc_node.send(9'h011, 1'b0, 1'b1, B);
        chk({31'h0, rx_overrun}, 32'h0);
        u_spc_node.send(9'h022, 1'b0, 1'b1, B);
        chk({31'h0, rx_overrun}, 32'h1);
        bus(1'b0, `SPC_OFS_BUFFER, 32'h0);
        chk(rd, 32'h22);
        $display("test overrun done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        reset_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_shift();
        t_tx9(8'hC8, B);
        t_tx9(8'h80, F);
        t_rx(8'hF0, 9'h03C, 1'b1, B, 1'b0, 1'b0);
        t_rx(8'hF0, 9'h13C, 1'b1, B, 1'b1, 1'b1);
        t_rx(8'h90, 9'h1A5, 1'b1, F, 1'b1, 1'b1);
        t_rx(8'h50, 9'h066, 1'b1, B, 1'b1, 1'b1);
        t_rx(8'h70, 9'h099, 1'b0, B, 1'b0, 1'b0);
        t_rx(8'h40, 9'h011, 1'b1, B, 1'b0, 1'b0);
        t_overrun();
        give_verdict();
    end
endmodule // spc_top_tb
`default_nettype wire
